// ### verilog/blc_cfg.svh
// Offsets, field positions and reset values of the backlight current code bank
`ifndef BLC_CFG_SVH
`define BLC_CFG_SVH

// Byte offsets on the host register port
`define BLC_OFF_DAYLIGHT_DIM 8'h0a
`define BLC_OFF_OFFICE_MAX 8'h0b
`define BLC_OFF_OFFICE_DIM 8'h0c
`define BLC_OFF_DARK_MAX 8'h0d

// Field layout of every current register
`define BLC_CODE_MSB 6
`define BLC_CODE_W 7
`define BLC_RSVD_BIT 7

// Reset value of every current code register
`define BLC_CODE_RESET 7'h00

// Code ends: zero current and full scale
`define BLC_CODE_ZERO 7'h00
`define BLC_CODE_FULL 7'h7f

// Ambient level encoding on the level select input
`define BLC_LVL_DAYLIGHT 2'h0
`define BLC_LVL_OFFICE 2'h1
`define BLC_LVL_DARK 2'h2

`endif

// ### verilog/blc_pkg.sv
// Types shared by the backlight current code bank
`default_nettype none

package blc_pkg;

	// State of one current code register
	typedef struct packed {
		logic [6:0] code;
	} blc_code_state_t;

	// State of the bank top level
	typedef struct packed {
		logic [7:0] rdata;
		logic rvalid;
		logic [6:0] drive_code;
		logic drive_off;
		logic drive_full;
	} blc_top_state_t;

endpackage : blc_pkg
`default_nettype wire

// ### verilog/blc_code_reg.sv
// One seven-bit current code register with a reserved top bit
`timescale 1ns/10ps
`default_nettype none
`include "blc_cfg.svh"

module blc_code_reg
	import blc_pkg::*;
#(
	parameter logic [7:0] ADDR = 8'h00
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [6:0] code_out
);

	blc_code_state_t s_q;
	blc_code_state_t s_d;

	// Take only the code field; the reserved bit is never stored
	always_comb begin
		s_d = s_q;
		if (wr_en_in && (addr_in == ADDR)) begin
			s_d.code = wdata_in[`BLC_CODE_MSB:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_q.code <= `BLC_CODE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign code_out = s_q.code;

	// A write to this offset lands in the code one edge later
	property p_code_write;
		@(posedge clk_in) disable iff (rst_in)
		(wr_en_in && addr_in == ADDR) |=> (code_out == $past(wdata_in[6:0]));
	endproperty
	a_code_write: assert property (p_code_write) else $error("code write lost");

	// Without a matching write the code holds
	property p_code_hold;
		@(posedge clk_in) disable iff (rst_in)
		!(wr_en_in && addr_in == ADDR) |=> $stable(code_out);
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("code changed without write");

endmodule : blc_code_reg
`default_nettype wire

// ### verilog/blc_regs.sv
// Backlight current code bank: four code registers and the active code select
`timescale 1ns/10ps
`default_nettype none
`include "blc_cfg.svh"

module blc_regs
	import blc_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic WR_EN_IN,
	input wire logic RD_EN_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic [1:0] LEVEL_IN,
	input wire logic DIM_TIMEOUT_IN,
	input wire logic DIM_FORCE_IN,
	input wire logic [6:0] DAYLIGHT_MAX_CODE_IN,
	input wire logic [6:0] DARK_DIM_CODE_IN,
	output logic [7:0] RDATA_OUT,
	output logic RVALID_OUT,
	output logic [6:0] CURRENT_CODE_OUT,
	output logic CURRENT_OFF_OUT,
	output logic CURRENT_FULL_OUT
);

	logic [6:0] daylight_dim_code;
	logic [6:0] office_max_code;
	logic [6:0] office_dim_code;
	logic [6:0] dark_max_code;
	logic dim_req;
	logic [6:0] sel_code;
	blc_top_state_t s_q;
	blc_top_state_t s_d;

	// The four current registers share one write port
	blc_code_reg #(.ADDR(`BLC_OFF_DAYLIGHT_DIM)) u_daylight_dim (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.wr_en_in(WR_EN_IN),
		.addr_in(ADDR_IN),
		.wdata_in(WDATA_IN),
		.code_out(daylight_dim_code)
	);

	blc_code_reg #(.ADDR(`BLC_OFF_OFFICE_MAX)) u_office_max (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.wr_en_in(WR_EN_IN),
		.addr_in(ADDR_IN),
		.wdata_in(WDATA_IN),
		.code_out(office_max_code)
	);

	blc_code_reg #(.ADDR(`BLC_OFF_OFFICE_DIM)) u_office_dim (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.wr_en_in(WR_EN_IN),
		.addr_in(ADDR_IN),
		.wdata_in(WDATA_IN),
		.code_out(office_dim_code)
	);

	blc_code_reg #(.ADDR(`BLC_OFF_DARK_MAX)) u_dark_max (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.wr_en_in(WR_EN_IN),
		.addr_in(ADDR_IN),
		.wdata_in(WDATA_IN),
		.code_out(dark_max_code)
	);

	// Dim wins over maximum whether it comes from the timer or from software
	assign dim_req = DIM_TIMEOUT_IN | DIM_FORCE_IN;

	// Active code select; an undefined level falls back to the dark pair
	always_comb begin
		case (LEVEL_IN)
			`BLC_LVL_DAYLIGHT: begin
				sel_code = dim_req ? daylight_dim_code : DAYLIGHT_MAX_CODE_IN;
			end
			`BLC_LVL_OFFICE: begin
				sel_code = dim_req ? office_dim_code : office_max_code;
			end
			default: begin
				sel_code = dim_req ? DARK_DIM_CODE_IN : dark_max_code;
			end
		endcase
	end

	// Read mux and drive outputs; reads of unmapped offsets return zero
	always_comb begin
		s_d = s_q;
		s_d.rvalid = RD_EN_IN;
		if (RD_EN_IN) begin
			case (ADDR_IN)
				`BLC_OFF_DAYLIGHT_DIM: begin
					s_d.rdata = {1'b0, daylight_dim_code};
				end
				`BLC_OFF_OFFICE_MAX: begin
					s_d.rdata = {1'b0, office_max_code};
				end
				`BLC_OFF_OFFICE_DIM: begin
					s_d.rdata = {1'b0, office_dim_code};
				end
				`BLC_OFF_DARK_MAX: begin
					s_d.rdata = {1'b0, dark_max_code};
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end
		s_d.drive_code = sel_code;
		// Flags tell the analog side about the two code ends, law independent
		s_d.drive_off = (sel_code == `BLC_CODE_ZERO);
		s_d.drive_full = (sel_code == `BLC_CODE_FULL);
	end

	// Outputs come straight from this register; costs one cycle of latency
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			s_q.rdata <= 8'h00;
			s_q.rvalid <= 1'b0;
			s_q.drive_code <= `BLC_CODE_RESET;
			s_q.drive_off <= 1'b1;
			s_q.drive_full <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign RDATA_OUT = s_q.rdata;
	assign RVALID_OUT = s_q.rvalid;
	assign CURRENT_CODE_OUT = s_q.drive_code;
	assign CURRENT_OFF_OUT = s_q.drive_off;
	assign CURRENT_FULL_OUT = s_q.drive_full;

	// Write to an offset followed next cycle by a read of it
	sequence s_write_then_read(logic [7:0] a);
		(WR_EN_IN && ADDR_IN == a) ##1 (RD_EN_IN && !WR_EN_IN && ADDR_IN == a);
	endsequence

	property p_daylight_dim_rw;
		@(posedge CLK_IN) disable iff (RST_IN)
		s_write_then_read(`BLC_OFF_DAYLIGHT_DIM) |=>
			(RVALID_OUT && RDATA_OUT == {1'b0, $past(WDATA_IN[6:0], 2)});
	endproperty
	a_daylight_dim_rw: assert property (p_daylight_dim_rw) else $error("daylight dim readback");

	property p_office_max_rw;
		@(posedge CLK_IN) disable iff (RST_IN)
		s_write_then_read(`BLC_OFF_OFFICE_MAX) |=>
			(RVALID_OUT && RDATA_OUT == {1'b0, $past(WDATA_IN[6:0], 2)});
	endproperty
	a_office_max_rw: assert property (p_office_max_rw) else $error("office max readback");

	property p_office_dim_rw;
		@(posedge CLK_IN) disable iff (RST_IN)
		s_write_then_read(`BLC_OFF_OFFICE_DIM) |=>
			(RVALID_OUT && RDATA_OUT == {1'b0, $past(WDATA_IN[6:0], 2)});
	endproperty
	a_office_dim_rw: assert property (p_office_dim_rw) else $error("office dim readback");

	property p_dark_max_rw;
		@(posedge CLK_IN) disable iff (RST_IN)
		s_write_then_read(`BLC_OFF_DARK_MAX) |=>
			(RVALID_OUT && RDATA_OUT == {1'b0, $past(WDATA_IN[6:0], 2)});
	endproperty
	a_dark_max_rw: assert property (p_dark_max_rw) else $error("dark max readback");

	// Reserved bit never reads as one
	property p_rsvd_zero;
		@(posedge CLK_IN) disable iff (RST_IN)
		RVALID_OUT |-> (RDATA_OUT[`BLC_RSVD_BIT] == 1'b0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

	// Office level with a dim request drives the office dim code
	property p_office_dim_drive;
		@(posedge CLK_IN) disable iff (RST_IN)
		(LEVEL_IN == `BLC_LVL_OFFICE && (DIM_TIMEOUT_IN || DIM_FORCE_IN)) |=>
			(CURRENT_CODE_OUT == $past(office_dim_code));
	endproperty
	a_office_dim_drive: assert property (p_office_dim_drive) else $error("office dim not driven");

	// Daylight level with forced dim drives the daylight dim code
	property p_daylight_force_drive;
		@(posedge CLK_IN) disable iff (RST_IN)
		(LEVEL_IN == `BLC_LVL_DAYLIGHT && DIM_FORCE_IN) |=>
			(CURRENT_CODE_OUT == $past(daylight_dim_code));
	endproperty
	a_daylight_force_drive: assert property (p_daylight_force_drive) else $error("forced dim lost");

	// Dark level without dim drives the dark maximum code
	property p_dark_max_drive;
		@(posedge CLK_IN) disable iff (RST_IN)
		(LEVEL_IN == `BLC_LVL_DARK && !DIM_TIMEOUT_IN && !DIM_FORCE_IN) |=>
			(CURRENT_CODE_OUT == $past(dark_max_code));
	endproperty
	a_dark_max_drive: assert property (p_dark_max_drive) else $error("dark max not driven");

	// End flags track the driven code
	property p_code_ends;
		@(posedge CLK_IN) disable iff (RST_IN)
		(CURRENT_OFF_OUT == (CURRENT_CODE_OUT == 7'h00)) &&
			(CURRENT_FULL_OUT == (CURRENT_CODE_OUT == 7'h7f));
	endproperty
	a_code_ends: assert property (p_code_ends) else $error("code end flag wrong");

endmodule : blc_regs
`default_nettype wire

// ### testbench/blc_regs_tb.sv
// Self-checking testbench of the backlight current code bank
`timescale 1ns/10ps
`default_nettype none
`include "blc_cfg.svh"

module testbench
	import blc_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tmo = 1'b0, frc = 1'b0;
	logic [7:0] adr = 8'h00, wd = 8'h00, rdo;
	logic [1:0] lvl = 2'h0;
	logic [6:0] dmx = 7'h00, ddm = 7'h00, cod, m[4];
	logic rv, off, full;
	logic [7:0] offs[4] = '{`BLC_OFF_DAYLIGHT_DIM, `BLC_OFF_OFFICE_MAX, `BLC_OFF_OFFICE_DIM,
		`BLC_OFF_DARK_MAX};
	logic [7:0] rq[$];
	logic [8:0] dq[$];
	int n_mismatch = 0, total_checks = 0;

	blc_regs blc_regs_inst (.CLK_IN(clk), .RST_IN(rst), .WR_EN_IN(wr), .RD_EN_IN(rd),
		.ADDR_IN(adr), .WDATA_IN(wd), .LEVEL_IN(lvl), .DIM_TIMEOUT_IN(tmo),
		.DIM_FORCE_IN(frc), .DAYLIGHT_MAX_CODE_IN(dmx), .DARK_DIM_CODE_IN(ddm),
		.RDATA_OUT(rdo), .RVALID_OUT(rv), .CURRENT_CODE_OUT(cod), .CURRENT_OFF_OUT(off),
		.CURRENT_FULL_OUT(full));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_rd

	task automatic cmp_drv(input logic [8:0] e, input logic [8:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_drv

	// Watcher: one tick after the falling edge so the rising edge's updates have landed
	always @(negedge clk) begin
		#1;
		if (rv === 1'b1) begin
			if (rq.size() == 0) cmp_rd(8'hxx, rdo);
			else cmp_rd(rq.pop_front(), rdo);
		end
		if (dq.size() > 0) cmp_drv(dq.pop_front(), {cod, off, full});
	end

	// One host byte cycle; strobes stay up into the next call, so a step that is not a bus call must drop them or the access repeats
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		wr = w;
		rd = r;
		adr = a;
		wd = d;
		if (r) rq.push_back(8'h00);
		@(negedge clk);
	endtask : bus

	// Read with the expected byte noted first
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
		void'(rq.pop_back());
	endtask : rd_exp

	// Present a drive condition, then note the expected code two falling edges later
	task automatic drv(input logic [1:0] l, input logic t, input logic f);
		logic [6:0] e;
		// Strobes left up by the last bus call would repeat its access
		wr = 1'b0;
		rd = 1'b0;
		lvl = l;
		tmo = t;
		frc = f;
		repeat (2) @(negedge clk);
		case (l)
			2'h0: e = (t | f) ? m[0] : dmx;
			2'h1: e = (t | f) ? m[2] : m[1];
			default: e = (t | f) ? ddm : m[3];
		endcase
		dq.push_back({e, e == `BLC_CODE_ZERO, e == `BLC_CODE_FULL});
	endtask : drv

	task automatic reset_dut(input int n);
		rst = 1'b1;
		repeat (n) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 4; i++) m[i] = `BLC_CODE_RESET;
	endtask : reset_dut

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// Watchdog sized well past the expected run length
	initial begin
		#20000;
		n_mismatch++;
		close_out();
	end

	initial begin
		logic [7:0] v;
		void'($urandom(32'h0cc07ba7));
		reset_dut(8);
		dmx = 7'($urandom());
		ddm = 7'($urandom());
		// Reset values and reads of unmapped offsets
		for (int i = 0; i < 4; i++) rd_exp(offs[i], 8'h00);
		rd_exp(8'h09, 8'h00);
		rd_exp(8'h0e, 8'h00);
		drv(2'h0, 1'b0, 1'b0);
		$display("test reset done");
		// Back-to-back writes with the reserved bit set, then back-to-back reads
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom()) | 8'h80;
			m[i] = v[6:0];
			bus(1'b1, 1'b0, offs[i], v);
		end
		bus(1'b1, 1'b0, 8'h0e, 8'hff);
		for (int i = 0; i < 4; i++) rd_exp(offs[i], {1'b0, m[i]});
		// Each write read back in the very next cycle, the tightest legal spacing
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom());
			m[i] = v[6:0];
			bus(1'b1, 1'b0, offs[i], v);
			rd_exp(offs[i], {1'b0, m[i]});
		end
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		$display("test readback done");
		// Read and write of one offset in the same cycle returns the old byte
		rq.push_back({1'b0, m[1]});
		bus(1'b1, 1'b1, offs[1], 8'h55);
		void'(rq.pop_back());
		m[1] = 7'h55;
		rd_exp(offs[1], 8'h55);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		$display("test collision done");
		// Every level with every dim cause
		for (int l = 0; l < 4; l++)
			for (int d = 0; d < 4; d++) drv(2'(l), d[0], d[1]);
		$display("test select done");
		// Code ends on the office maximum path
		for (int i = 0; i < 8; i++) begin
			m[1] = i[0] ? `BLC_CODE_FULL : `BLC_CODE_ZERO;
			bus(1'b1, 1'b0, offs[1], {1'b1, m[1]});
			bus(1'b0, 1'b0, 8'h00, 8'h00);
			drv(2'h1, 1'b0, 1'b0);
		end
		$display("test ends done");
		// Reset in mid-run clears the bank
		reset_dut(3);
		for (int i = 0; i < 4; i++) rd_exp(offs[i], 8'h00);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		drv(2'h3, 1'b0, 1'b0);
		repeat (3) @(negedge clk);
		// Any note left unanswered means an answer never came
		if (rq.size() != 0 || dq.size() != 0) n_mismatch++;
		$display("test midreset done");
		close_out();
	end
endmodule : testbench
`default_nettype wire
